// *** rtl/pptc_pkg.sv ***
// constants for the power pwm time-base control block
// assumes a 32-bit apb master and one 100 MHz system clock
// How it works
// - module-enable bit 15 runs or stops the whole pwm time base
// - idle-stop bit 13 halts the time base while the cpu idles
// - special-event pending bit 12 reads 1 while that interrupt waits
// - special-event irq enable bit 11 gates the special-event interrupt
// - immediate-update bit 10 copies period at once, else at rollover
// - sync-in polarity bit 9 makes the sync input active low
// - sync-out enable bit 8 drives the sync output pin
// - external-sync enable bit 7 lets the selected source restart the base
// - source select 000 picks the sync pin; other codes are reserved
// - postscale field divides special-event triggers by value plus one
// - period register keeps bits 15-3; bits 2-0 read zero
// - compare register keeps bits 15-3; match raises a special event
// - fault pending bit 15 clears when fault enable is written zero
// - current-limit pending bit 14 clears when its enable is written zero
// - trigger pending bit 13 clears when its enable is written zero
// - fault enable bit 12 allows fault requests, else holds pending clear
// - master-duty select makes a generator use the master duty value
package pptc_pkg;
	localparam logic [7:0] OFS_TBCTL = 8'h00;
	localparam logic [7:0] OFS_PER = 8'h04;
	localparam logic [7:0] OFS_SEVCMP = 8'h08;
	localparam logic [7:0] OFS_MDC = 8'h0C;
	localparam logic [7:0] OFS_GEN0 = 8'h10;
	localparam int TB_EN = 15;
	localparam int TB_IDLE = 13;
	localparam int TB_SEPEND = 12;
	localparam int TB_SPECIAL_EVENT_IRQ_ENABLE = 11;
	localparam int TB_IMMEDIATE_PERIOD_UPDATE = 10;
	localparam int TB_SPOL = 9;
	localparam int TB_SOEN = 8;
	localparam int TB_SYEN = 7;
	localparam int TB_SRC = 4;
	localparam int TB_PS = 0;
	localparam logic [2:0] SRC_PIN = 3'h0;
	localparam logic [15:0] TB_WMASK = 16'hAFFF;
	localparam logic [15:0] LOW3_MASK = 16'hFFF8;
	localparam int GC_FPEND = 15;
	localparam int GC_IEN = 10;
	localparam int GC_MASTER_DUTY_SELECT = 8;
	localparam logic [15:0] GC_WMASK = 16'h1FC3;
	localparam logic [15:0] RST_VAL = 16'h0000;
	localparam int MAX_GEN = 8;
endpackage

// *** rtl/pptc_gen_if.sv ***
// per-generator carrier between the top and its status keeper
// assumes one instance per generator, all on clk_sys
interface pptc_gen_if;
	logic [2:0] evt;
	logic [2:0] ien;
	logic ien_wr;
	logic [2:0] pend;
	logic irq;
	modport top (output evt, output ien, output ien_wr, input pend, input irq);
	modport gen (input evt, input ien, input ien_wr, output pend, output irq);
endinterface

// *** rtl/pptc_postscaler.sv ***
// event postscaler: one tick per ratio+1 input events
// assumes evt is a one-cycle pulse and clr holds the count at zero
module pptc_postscaler #(
	parameter int W = 4
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic clr,
	input wire logic evt,
	input wire logic [W-1:0] ratio,
	output logic tick_ff
);
	logic [W-1:0] cnt_ff;

	// count events; ratio changes take effect on the next match
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_ff <= '0;
			tick_ff <= 1'b0;
		end
		else if (clr)
		begin
			cnt_ff <= '0;
			tick_ff <= 1'b0;
		end
		else
		begin
			tick_ff <= 1'b0;
			if (evt)
			begin
				if (cnt_ff >= ratio)
				begin
					cnt_ff <= '0;
					tick_ff <= 1'b1;
				end
				else
					cnt_ff <= cnt_ff + 1'b1;
			end
		end
	end
endmodule

// *** rtl/pptc_gen_status.sv ***
// fault, current-limit and trigger pending bits of one generator
// assumes ien holds the enable bits, already the new ones in the cycle that
// ien_wr pulses for a register write
module pptc_gen_status (
	input wire logic clk_sys,
	input wire logic arst_n,
	pptc_gen_if.gen g
);
	logic [2:0] pend_ff;
	logic [2:0] nxt_pend;
	logic irq_ff;

	// a write with an enable at zero clears; an event still enabled wins
	always_comb
	begin
		nxt_pend = pend_ff;
		if (g.ien_wr)
			nxt_pend = pend_ff & g.ien;
		nxt_pend = nxt_pend | (g.evt & g.ien);
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pend_ff <= 3'h0;
			irq_ff <= 1'b0;
		end
		else
		begin
			pend_ff <= nxt_pend;
			irq_ff <= |nxt_pend;
		end
	end

	assign g.pend = pend_ff;
	assign g.irq = irq_ff;
endmodule

// *** rtl/pptc_top.sv ***
// power pwm time base, special event and generator status registers
// behind an apb slave port that answers without wait states
// assumes an apb master on clk_sys; event inputs are one-cycle pulses
// assumes software leaves the sync source at the pin code
module pptc_top
	import pptc_pkg::*;
#(
	parameter int N_GEN = 4
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cpu_idle,
	input wire logic sync_input_pin,
	input wire logic [N_GEN-1:0] fault_evt,
	input wire logic [N_GEN-1:0] current_limit_evt,
	input wire logic [N_GEN-1:0] trigger_evt,
	input wire logic [N_GEN-1:0][15:0] gen_own_duty,
	output logic [N_GEN-1:0][15:0] gen_duty,
	output logic [N_GEN-1:0] gen_irq,
	output logic [15:0] primary_timebase_counter,
	output logic sync_output_pin,
	output logic sync_output_oe,
	output logic special_event_trigger,
	output logic special_event_irq
);
	// a generator index must fit the address map
	if (N_GEN < 1 || N_GEN > MAX_GEN)
		$error("N_GEN out of range");

	logic [15:0] tbctl_ff;
	logic [15:0] per_ff;
	logic [15:0] act_per_ff;
	logic [15:0] sevcmp_ff;
	logic [15:0] mdc_ff;
	logic [N_GEN-1:0][15:0] gctl_ff;
	logic [15:0] cnt_ff;
	logic sepend_ff;
	logic seirq_ff;
	logic sync_prev_ff;
	logic sync_out_ff;
	logic sync_oe_ff;
	logic [N_GEN-1:0][15:0] duty_ff;
	logic [31:0] rdata_ff;
	logic ready_ff;
	logic err_ff;
	logic [15:0] nxt_rd;
	logic nxt_err;
	logic wr_en;
	logic setup;
	logic run;
	logic sync_lvl;
	logic sync_hit;
	logic roll;
	logic sev_match;
	logic se_tick;
	logic [N_GEN-1:0] gen_sel;
	logic [N_GEN-1:0][2:0] gen_pend;
	logic [N_GEN-1:0] gen_irq_w;
	logic wr_tbctl;
	logic wr_per;
	logic wr_sevcmp;
	logic wr_mdc;
	logic sepend_clr;
	logic src_pin_sel;
	logic [N_GEN-1:0][2:0] gen_ien;

	pptc_gen_if gif [N_GEN] ();

	// apb: setup phase decodes, access phase completes with one wait-free cycle
	assign setup = psel && !penable;
	assign wr_en = psel && penable && ready_ff && pwrite && !err_ff;

	// one strobe per register, so the write paths share a single decode
	assign wr_tbctl = wr_en && paddr == OFS_TBCTL;
	assign wr_per = wr_en && paddr == OFS_PER;
	assign wr_sevcmp = wr_en && paddr == OFS_SEVCMP;
	assign wr_mdc = wr_en && paddr == OFS_MDC;

	// a zero written to the pending bit clears it, a one is ignored
	assign sepend_clr = wr_tbctl && !pwdata[TB_SEPEND];

	always_comb
	begin
		gen_sel = '0;
		for (int i = 0; i < N_GEN; i++)
			gen_sel[i] = (paddr == OFS_GEN0 + 8'(4 * i));
	end

	// read mux and unmapped-address detection
	always_comb
	begin
		nxt_rd = 16'h0000;
		nxt_err = 1'b0;
		unique case (paddr)
			OFS_TBCTL:
				nxt_rd = {tbctl_ff[15:13], sepend_ff, tbctl_ff[11:0]};
			OFS_PER:
				nxt_rd = per_ff & LOW3_MASK;
			OFS_SEVCMP:
				nxt_rd = sevcmp_ff & LOW3_MASK;
			OFS_MDC:
				nxt_rd = mdc_ff;
			default:
			begin
				nxt_err = ~|gen_sel;
				for (int i = 0; i < N_GEN; i++)
					if (gen_sel[i])
						nxt_rd = gctl_ff[i] | {gen_pend[i], 13'h0000};
			end
		endcase
	end

	// answer registered so every bus output comes from a flip-flop
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rdata_ff <= 32'h00000000;
			ready_ff <= 1'b0;
			err_ff <= 1'b0;
		end
		else
		begin
			ready_ff <= setup;
			if (setup)
			begin
				rdata_ff <= pwrite ? 32'h00000000 : {16'h0000, nxt_rd};
				err_ff <= nxt_err;
			end
			else
			begin
				err_ff <= 1'b0;
			end
		end
	end

	// time-base control; the pending bit is kept apart since hardware sets it
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			tbctl_ff <= RST_VAL;
		else if (wr_tbctl)
			tbctl_ff <= pwdata[15:0] & TB_WMASK;
	end

	// period, compare and master duty storage
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			per_ff <= RST_VAL;
			sevcmp_ff <= RST_VAL;
			mdc_ff <= RST_VAL;
		end
		else
		begin
			if (wr_per)
				per_ff <= pwdata[15:0] & LOW3_MASK;
			if (wr_sevcmp)
				sevcmp_ff <= pwdata[15:0] & LOW3_MASK;
			if (wr_mdc)
				mdc_ff <= pwdata[15:0]; // out-of-range values are software's concern
		end
	end

	// generator control: status bits are never written by software
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			gctl_ff <= '0;
		else
			for (int i = 0; i < N_GEN; i++)
				if (wr_en && gen_sel[i])
					gctl_ff[i] <= pwdata[15:0] & GC_WMASK;
	end

	// run condition and external sync detection
	assign run = tbctl_ff[TB_EN] && !(cpu_idle && tbctl_ff[TB_IDLE]);
	assign sync_lvl = sync_input_pin ^ tbctl_ff[TB_SPOL];

	// reserved source codes select nothing, so only the pin code can sync
	assign src_pin_sel = tbctl_ff[TB_SRC+:3] == SRC_PIN;
	assign sync_hit = tbctl_ff[TB_SYEN] && src_pin_sel && sync_lvl && !sync_prev_ff;
	assign roll = run && (sync_hit || cnt_ff >= act_per_ff);
	assign sev_match = run && cnt_ff == sevcmp_ff;

	// sync level history for edge detection
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			sync_prev_ff <= 1'b0;
		else
			sync_prev_ff <= sync_lvl;
	end

	// primary time base counter; held at zero while disabled
	// spans 0..active period, so the period value is the last count shown
	// idle stop freezes it in place rather than clearing it
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			cnt_ff <= 16'h0000;
		else if (!tbctl_ff[TB_EN])
			cnt_ff <= 16'h0000;
		else if (roll)
			cnt_ff <= 16'h0000;
		else if (run)
			cnt_ff <= cnt_ff + 16'h0001;
	end

	// active period: immediate copy or deferred to rollover, avoiding a
	// mid-period shrink that could skip the restart point
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			act_per_ff <= RST_VAL;
		else if (tbctl_ff[TB_IMMEDIATE_PERIOD_UPDATE] || !tbctl_ff[TB_EN] || roll)
			act_per_ff <= per_ff;
	end

	// special event postscaler
	pptc_postscaler #(
		.W(4)
	) u_ps (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.clr(!tbctl_ff[TB_EN]),
		.evt(sev_match),
		.ratio(tbctl_ff[TB_PS+:4]),
		.tick_ff(se_tick)
	);

	// special event pending: set on enabled trigger, cleared by writing zero;
	// a trigger in the clearing cycle keeps it set
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			sepend_ff <= 1'b0;
		else if (se_tick && tbctl_ff[TB_SPECIAL_EVENT_IRQ_ENABLE])
			sepend_ff <= 1'b1;
		else if (sepend_clr)
			sepend_ff <= 1'b0;
	end

	// special event interrupt request, blocked by the enable bit
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			seirq_ff <= 1'b0;
		else
			seirq_ff <= sepend_ff && tbctl_ff[TB_SPECIAL_EVENT_IRQ_ENABLE];
	end

	// sync output: one pulse per rollover while enabled
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync_out_ff <= 1'b0;
			sync_oe_ff <= 1'b0;
		end
		else
		begin
			sync_out_ff <= tbctl_ff[TB_SOEN] && roll;
			sync_oe_ff <= tbctl_ff[TB_SOEN];
		end
	end

	// enable bits as the status keepers see them: during a write the new
	// value counts, so an enable written to zero clears its pending bit at
	// that very edge and no event of the same cycle can set it again
	always_comb
	begin
		gen_ien = '0;
		for (int i = 0; i < N_GEN; i++)
			if (wr_en && gen_sel[i])
				gen_ien[i] = pwdata[GC_IEN+:3];
			else
				gen_ien[i] = gctl_ff[i][GC_IEN+:3];
	end

	// per-generator status keepers
	for (genvar i = 0; i < N_GEN; i++)
	begin : g_gen
		assign gif[i].evt = {fault_evt[i], current_limit_evt[i], trigger_evt[i]};
		assign gif[i].ien = gen_ien[i];
		assign gif[i].ien_wr = wr_en && gen_sel[i];
		assign gen_pend[i] = gif[i].pend;
		assign gen_irq_w[i] = gif[i].irq;
		pptc_gen_status u_gs (
			.clk_sys(clk_sys),
			.arst_n(arst_n),
			.g(gif[i].gen)
		);
	end

	// duty source choice per generator
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			duty_ff <= '0;
		else
			for (int i = 0; i < N_GEN; i++)
				duty_ff[i] <= gctl_ff[i][GC_MASTER_DUTY_SELECT] ? mdc_ff : gen_own_duty[i];
	end

	assign prdata = rdata_ff;
	assign pready = ready_ff;
	assign pslverr = err_ff;
	assign gen_duty = duty_ff;
	assign gen_irq = gen_irq_w;
	assign primary_timebase_counter = cnt_ff;
	assign sync_output_pin = sync_out_ff;
	assign sync_output_oe = sync_oe_ff;
	assign special_event_trigger = se_tick;
	assign special_event_irq = seirq_ff;
endmodule

// *** tb/pptc_top_checker.sv ***
// port assertions for the pwm time-base block
// assumes one clock and the package register map
module pptc_top_checker
	import pptc_pkg::*;
#(
	parameter int N_GEN = 4
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic cpu_idle,
	input wire logic [N_GEN-1:0] fault_evt,
	input wire logic [N_GEN-1:0] current_limit_evt,
	input wire logic [N_GEN-1:0] trigger_evt,
	input wire logic [N_GEN-1:0] gen_irq,
	input wire logic [15:0] primary_timebase_counter,
	input wire logic sync_output_pin,
	input wire logic special_event_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] ctl_ff;
	wire [15:0] cnt = primary_timebase_counter;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	// shadow of the control word, the registers being out of sight
	always_ff @(posedge clk_sys or negedge arst_n)
		if (!arst_n)
			ctl_ff <= 16'h0000;
		else if (psel && penable && pready && pwrite && paddr == OFS_TBCTL)
			ctl_ff <= pwdata[15:0];
	AST_RDY: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	AST_OFF: assert property (!ctl_ff[15] |=> cnt == 16'h0000)
		else $error("counter runs while off");
	AST_IDLE: assert property (ctl_ff[15] && ctl_ff[13] && !ctl_ff[7] && cpu_idle |=> $stable(cnt))
		else $error("counter runs in idle");
	AST_RUN: assert property (ctl_ff[15] && !(ctl_ff[13] && cpu_idle) && cnt != 16'h0000 |=> $changed(cnt))
		else $error("counter stuck");
	AST_STEP: assert property ($changed(cnt) |-> cnt == $past(cnt) + 16'h0001 || cnt == 16'h0000)
		else $error("counter jump");
	AST_SOUT: assert property (sync_output_pin |-> cnt == 16'h0000 && $past(ctl_ff[8]))
		else $error("bad sync out");
	AST_SEI: assert property (special_event_irq |-> $past(ctl_ff[11]))
		else $error("irq while masked");
	AST_GIRQ: assert property ($rose(gen_irq[0]) |-> $past(fault_evt[0] || current_limit_evt[0] || trigger_evt[0]))
		else $error("irq without event");
	cover property (sync_output_pin);
	cover property (special_event_irq);
	cover property ($rose(gen_irq[0]));
endmodule
bind pptc_top pptc_top_checker #(.N_GEN(N_GEN)) u_pptc_top_checker (
	.clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .cpu_idle,
	.fault_evt, .current_limit_evt, .trigger_evt, .gen_irq, .primary_timebase_counter,
	.sync_output_pin, .special_event_irq
);

// *** tb/pptc_sync_src.sv ***
// far-side sync source: one active cycle per request
// assumes requests arrive just after a clock edge
module pptc_sync_src (
	input wire logic clk_sys,
	input wire logic fire,
	input wire logic pol,
	output logic sync_input_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic act_ff = 1'b0;
	// rests at the inactive level that the polarity names
	always_ff @(posedge clk_sys)
		act_ff <= fire;
	assign sync_input_pin = act_ff ^ pol;
endmodule

// *** tb/pptc_top_tb.sv ***
// random and corner tests of the pwm time-base block
// assumes the checker binds itself to the top
module pptc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pptc_pkg::*;
	logic clk_sys = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic cpu_idle = 1'b0, fire = 1'b0, pol = 1'b0, err, pready, pslverr, sync_input_pin;
	logic sop, soe, sev, sei;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [2:0][3:0] ev = '0;
	logic [3:0][15:0] own = '0, duty;
	logic [3:0] girq;
	logic [15:0] cnt, v;
	int miscompares = 0, check_count = 0, n;
	always #5 clk_sys = ~clk_sys;
	pptc_top u_pptc_top (
		.clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .cpu_idle, .sync_input_pin, .fault_evt(ev[0]), .current_limit_evt(ev[1]),
		.trigger_evt(ev[2]), .gen_own_duty(own), .gen_duty(duty), .gen_irq(girq),
		.primary_timebase_counter(cnt), .sync_output_pin(sop), .sync_output_oe(soe),
		.special_event_trigger(sev), .special_event_irq(sei)
	);
	pptc_sync_src u_pptc_sync_src (.clk_sys, .fire, .pol, .sync_input_pin);
	task automatic tally_and_finish();
		if (miscompares == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: %h, expected %h", $time, got, exp);
		end
	endtask
	// request held until ready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do
			@(posedge clk_sys) n++;
		while (pready !== 1'b1 && n < 9);
		if (pready !== 1'b1)
		begin
			miscompares++;
			tally_and_finish();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [15:0] e);
		apb(1'b0, a, 16'h0000);
		chk(rd, {16'h0000, e});
	endtask
	// status bits come from hardware only
	function automatic logic [15:0] gen_exp(logic [15:0] d, logic [2:0] p);
		return (d & GC_WMASK) | {p, 13'h0000};
	endfunction
	initial
	begin
		void'($urandom(32'h77E44BE2));
		own <= {$urandom, $urandom};
		repeat (16) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		// reset values, last address unmapped
		for (int a = 0; a < 9; a++)
			rdc(8'(a * 4), 16'h0000);
		chk(32'(err), 32'h1);
		for (int i = 0; i < 8; i++)
		begin
			v = 16'($urandom);
			apb(1'b1, OFS_PER, v);
			rdc(OFS_PER, v & LOW3_MASK);
			apb(1'b1, OFS_SEVCMP, ~v);
			rdc(OFS_SEVCMP, ~v & LOW3_MASK);
			apb(1'b1, OFS_GEN0 + 8'(i % 4 * 4), v);
			rdc(OFS_GEN0 + 8'(i % 4 * 4), gen_exp(v, 3'h0));
		end
		v = 16'h0008 + 16'($urandom_range(16'hFFE7));
		apb(1'b1, OFS_MDC, v);
		rdc(OFS_MDC, v);
		apb(1'b1, OFS_GEN0 + 8'h04, 16'h0000);
		apb(1'b1, OFS_GEN0, 16'h0100);
		repeat (2) @(posedge clk_sys);
		chk({duty[0], duty[1]}, {v, own[1]});
		apb(1'b1, OFS_PER, 16'h0010);
		apb(1'b1, OFS_SEVCMP, 16'h0008);
		// two pulses per two full postscale rounds
		for (int ps = 0; ps < 16; ps++)
		begin
			apb(1'b1, OFS_TBCTL, 16'h0000);
			apb(1'b1, OFS_TBCTL, 16'h8D00 | 16'(ps));
			repeat (40) @(posedge clk_sys);
			n = 0;
			repeat (34 * (ps + 1)) @(posedge clk_sys) n += sev;
			chk(n, 32'h2);
		end
		rdc(OFS_TBCTL, 16'h9D0F);
		chk(32'({sei, soe}), 32'h3);
		apb(1'b1, OFS_TBCTL, 16'h850F);
		rdc(OFS_TBCTL, 16'h850F);
		chk(32'({sei, soe}), 32'h1);
		apb(1'b1, OFS_TBCTL, 16'hA000);
		cpu_idle <= 1'b1;
		repeat (5) @(posedge clk_sys);
		cpu_idle <= 1'b0;
		apb(1'b1, OFS_PER, 16'h0100);
		for (int p = 0; p < 4; p++)
		begin
			pol <= p[0];
			apb(1'b1, OFS_TBCTL, 16'h0000);
			apb(1'b1, OFS_TBCTL, 16'h8400 | 16'(p % 2 * 512 + p / 2 * 128));
			repeat (20) @(posedge clk_sys);
			fire <= 1'b1;
			@(posedge clk_sys);
			fire <= 1'b0;
			repeat (3) @(posedge clk_sys);
			chk(32'(cnt < 16'h0008), 32'(p / 2));
		end
		for (int m = 0; m < 2; m++)
		begin
			apb(1'b1, OFS_TBCTL, 16'h0000);
			@(posedge clk_sys);
			chk(32'(cnt), 32'h0);
			apb(1'b1, OFS_PER, 16'h0100);
			apb(1'b1, OFS_TBCTL, m ? 16'h8400 : 16'h8000);
			repeat (40) @(posedge clk_sys);
			apb(1'b1, OFS_PER, 16'h0010);
			repeat (2) @(posedge clk_sys);
			chk(32'(cnt > 16'h0010), 32'(m == 0));
		end
		for (int k = 0; k < 3; k++)
		begin
			v = 16'h1000 >> k;
			apb(1'b1, OFS_GEN0, v);
			ev[k][0] <= 1'b1;
			@(posedge clk_sys);
			ev[k][0] <= 1'b0;
			@(posedge clk_sys);
			chk(32'(girq[0]), 32'h1);
			rdc(OFS_GEN0, gen_exp(v, 3'h4 >> k));
			apb(1'b1, OFS_GEN0, 16'h0000);
			ev[k][0] <= 1'b1;
			@(posedge clk_sys);
			ev[k][0] <= 1'b0;
			rdc(OFS_GEN0, 16'h0000);
			chk(32'(girq[0]), 32'h0);
		end
		tally_and_finish();
	end
endmodule
